// ==== rrf_pkg.sv ====
/*
 * Shared constants and types for the repeater forwarding control block:
 * parameter store layout, factory defaults, mode codes and the reload time.
 * Assumes a single 125 MHz core clock and packets delivered as whole words.
 */
package rrf_pkg;

    // ----------------------------------------------------------------
    // Parameter store layout
    // ----------------------------------------------------------------
    localparam logic [2:0] IDX_HEADER  = 3'h0;  // Fixed header byte, read only
    localparam logic [2:0] IDX_ADDR_HI = 3'h1;
    localparam logic [2:0] IDX_ADDR_LO = 3'h2;
    localparam logic [2:0] IDX_REG0    = 3'h3;  // Serial rate, framing, air rate
    localparam logic [2:0] IDX_REG1    = 3'h4;
    localparam logic [2:0] IDX_CHANNEL = 3'h5;
    localparam logic [2:0] IDX_NETWORK_IDENTIFIER   = 3'h6;
    localparam logic [2:0] IDX_OPT3    = 3'h7;
    localparam int         STORE_WORDS = 8;

    // ----------------------------------------------------------------
    // Factory defaults
    // ----------------------------------------------------------------
    localparam logic [7:0] DEF_HEADER  = 8'hC0;
    localparam logic [7:0] DEF_ADDR_HI = 8'h00;
    localparam logic [7:0] DEF_ADDR_LO = 8'h00;
    localparam logic [7:0] DEF_REG0    = 8'h62; // 9600 baud, 8N1, 2.4 kbps air
    localparam logic [7:0] DEF_REG1    = 8'h00;
    localparam logic [7:0] DEF_CHANNEL = 8'h12;
    localparam logic [7:0] DEF_NETWORK_IDENTIFIER   = 8'h00;
    localparam logic [7:0] DEF_OPT3    = 8'h00;

    // ----------------------------------------------------------------
    // Fields, modes and limits
    // ----------------------------------------------------------------
    localparam int         OPT3_REPEAT_BIT = 5;
    localparam logic [7:0] CHANNEL_MAX     = 8'h50;  // Highest legal channel, 80
    localparam logic [1:0] MODE_NORMAL     = 2'h0;
    localparam logic [1:0] MODE_WOR        = 2'h1;
    localparam logic [1:0] MODE_CONFIG     = 2'h2;
    localparam logic [1:0] MODE_SLEEP      = 2'h3;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 8;
    localparam int RELOAD_TIME_NS = 20000;
    localparam int RELOAD_CYCLES  = (RELOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  net_id;
        logic [15:0] dst_addr;
        logic [15:0] src_addr;
        logic [7:0]  data;
    } rrf_pkt_s;

    typedef struct packed {
        logic [7:0] addr_high_byte;
        logic [7:0] addr_low_byte;
        logic [7:0] network_identifier;
        logic [7:0] channel;
        logic [7:0] option_register_three;
    } rrf_cfg_s;

    typedef enum logic [1:0] {
        ST_RELOAD = 2'b01,
        ST_RUN    = 2'b10
    } rrf_state_e;

endpackage : rrf_pkg

// ==== rrf_param_store.sv ====
/*
 * Parameter store: eight byte-wide words with a registered read port and a
 * registered view of the working fields. Factory restore loads the defaults.
 * Assumes the caller only presents writes it has already qualified.
 */
`timescale 1ns/1ps
module rrf_param_store
    import rrf_pkg::*;
#(
    parameter int WORDS = STORE_WORDS
) (
    // Clock and control
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic       factory_in,
    // Access port
    input  wire logic       wr_in,
    input  wire logic [2:0] idx_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] rdata_out,
    output rrf_cfg_s        cfg_out
);

    initial begin
        if (WORDS != STORE_WORDS) $error("param store needs exactly eight words");
    end

    logic [7:0] mem_r [WORDS];
    logic       load_defaults;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    assign load_defaults = rst_in || factory_in;

    // Defaults on reset or factory restore, else qualified writes
    always_ff @(posedge clk_in) begin
        if (load_defaults) begin
            mem_r[IDX_HEADER]  <= DEF_HEADER;
            mem_r[IDX_ADDR_HI] <= DEF_ADDR_HI;
            mem_r[IDX_ADDR_LO] <= DEF_ADDR_LO;
            mem_r[IDX_REG0]    <= DEF_REG0;
            mem_r[IDX_REG1]    <= DEF_REG1;
            mem_r[IDX_CHANNEL] <= DEF_CHANNEL;
            mem_r[IDX_NETWORK_IDENTIFIER]   <= DEF_NETWORK_IDENTIFIER;
            mem_r[IDX_OPT3]    <= DEF_OPT3;
        end else if (ce_in && wr_in && idx_in != IDX_HEADER) begin
            mem_r[idx_in] <= wdata_in;
        end
    end

    // Registered read data and field view
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
            cfg_out   <= '0;
        end else if (ce_in) begin
            rdata_out                     <= mem_r[idx_in];
            cfg_out.addr_high_byte        <= mem_r[IDX_ADDR_HI];
            cfg_out.addr_low_byte         <= mem_r[IDX_ADDR_LO];
            cfg_out.network_identifier    <= mem_r[IDX_NETWORK_IDENTIFIER];
            cfg_out.channel               <= mem_r[IDX_CHANNEL];
            cfg_out.option_register_three <= mem_r[IDX_OPT3];
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_factory_block;
        @(posedge clk_in) disable iff (rst_in)
        factory_in |=> (mem_r[IDX_HEADER] == DEF_HEADER && mem_r[IDX_REG0] == DEF_REG0
                        && mem_r[IDX_CHANNEL] == DEF_CHANNEL && mem_r[IDX_ADDR_HI] == DEF_ADDR_HI);
    endproperty
    a_factory_block: assert property (p_factory_block) else $error("factory block wrong");

endmodule : rrf_param_store

// ==== rrf_repeater_ctrl.sv ====
/*
 * Repeater forwarding control: mode tracking, parameter reload with status
 * pin, host data gating and two-way relay between two paired networks.
 * Assumes the radio side hands over one decoded packet word per rx_valid_in
 * and takes one packet word per air_tx_valid_out without back-pressure.
 */
`timescale 1ns/1ps
module rrf_repeater_ctrl
    import rrf_pkg::*;
#(
    parameter int RELOAD_LEN = RELOAD_CYCLES
) (
    // Clock, reset, enable
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    input  wire logic       clk_en_in,
    // Mode pins and factory restore
    input  wire logic [1:0] mode_select_pins_in,
    input  wire logic       factory_reset_in,
    // Parameter access
    input  wire logic       cfg_wr_in,
    input  wire logic [2:0] cfg_idx_in,
    input  wire logic [7:0] cfg_wdata_in,
    output logic      [7:0] cfg_rdata_out,
    // Packets heard on air
    input  wire logic       rx_valid_in,
    input  rrf_pkt_s        rx_pkt_in,
    // Host data for transmission
    input  wire logic       host_tx_valid_in,
    input  wire logic [7:0] host_tx_data_in,
    output logic            host_tx_ready_out,
    // Packets to transmit
    output logic            air_tx_valid_out,
    output rrf_pkt_s        air_tx_pkt_out,
    // Data to host
    output logic            host_rx_valid_out,
    output logic      [7:0] host_rx_data_out,
    // Status
    output logic            aux_out,
    output logic            low_power_out,
    output logic            repeater_active_out,
    output logic      [1:0] mode_out
);

    initial begin
        if (RELOAD_LEN < 1 || RELOAD_LEN > 4095) $error("reload length out of range");
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [1:0]  ms1_r, ms2_r, ms3_r;
    logic [1:0]  mode_r, mode_nxt;
    rrf_state_e  st_r, st_nxt;
    logic [11:0] cnt_r, cnt_nxt;
    rrf_cfg_s    cfg_r, store_cfg;
    logic        rep_on, leave_sleep, reload_done, wr_ok;
    logic        hit_hi, hit_lo, fwd_go, host_take, deliver;
    logic [15:0] own_addr;
    rrf_pkt_s    fwd_pkt, host_pkt;
    logic        ready_nxt, lowp_nxt, active_nxt;

    // ----------------------------------------------------------------
    // Mode pin synchroniser
    // ----------------------------------------------------------------
    // Three stages; a change is taken once stages two and three agree
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ms1_r <= MODE_NORMAL;
            ms2_r <= MODE_NORMAL;
            ms3_r <= MODE_NORMAL;
        end else if (clk_en_in) begin
            ms1_r <= mode_select_pins_in;
            ms2_r <= ms1_r;
            ms3_r <= ms2_r;
        end
    end

    assign mode_nxt    = (ms2_r == ms3_r) ? ms3_r : mode_r;
    assign leave_sleep = (mode_r == MODE_SLEEP) && (mode_nxt != MODE_SLEEP);

    // ----------------------------------------------------------------
    // Parameter store and access qualification
    // ----------------------------------------------------------------
    // Writes only in configuration mode, after reload, with channel in range
    assign wr_ok = cfg_wr_in && (mode_r == MODE_CONFIG) && (st_r == ST_RUN)
                   && !(cfg_idx_in == IDX_CHANNEL && cfg_wdata_in > CHANNEL_MAX);

    rrf_param_store #(
        .WORDS (STORE_WORDS)
    ) u_store (
        .clk_in     (core_clk_in),
        .rst_in     (rst_in),
        .ce_in      (clk_en_in),
        .factory_in (factory_reset_in && clk_en_in),
        .wr_in      (wr_ok),
        .idx_in     (cfg_idx_in),
        .wdata_in   (cfg_wdata_in),
        .rdata_out  (cfg_rdata_out),
        .cfg_out    (store_cfg)
    );

    // ----------------------------------------------------------------
    // Reload sequencer
    // ----------------------------------------------------------------
    assign reload_done = (cnt_r == 12'(RELOAD_LEN - 1));

    // Reset, or a sleep exit or factory restore while in ST_RUN, start a new reload
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            ST_RELOAD: begin
                cnt_nxt = cnt_r + 12'h001;
                if (reload_done) begin
                    st_nxt  = ST_RUN;
                    cnt_nxt = 12'h000;
                end
            end
            ST_RUN: begin
                if (leave_sleep || factory_reset_in) begin
                    st_nxt  = ST_RELOAD;
                    cnt_nxt = 12'h000;
                end
            end
            default: begin
                st_nxt  = ST_RELOAD;
                cnt_nxt = 12'h000;
            end
        endcase
    end

    // State, counter, mode and working parameters
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_r   <= ST_RELOAD;
            cnt_r  <= 12'h000;
            mode_r <= MODE_NORMAL;
            cfg_r  <= '0;
        end else if (clk_en_in) begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            mode_r <= mode_nxt;
            if (st_nxt == ST_RUN) begin
                cfg_r <= store_cfg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Forwarding decode
    // ----------------------------------------------------------------
    assign rep_on   = cfg_r.option_register_three[OPT3_REPEAT_BIT];
    assign own_addr = {cfg_r.addr_high_byte, cfg_r.addr_low_byte};
    // Address bytes act as network pair; own identifier is not consulted
    assign hit_hi   = rx_pkt_in.net_id == cfg_r.addr_high_byte;
    assign hit_lo   = rx_pkt_in.net_id == cfg_r.addr_low_byte;
    // One relay per heard packet, never back onto its own network
    assign fwd_go   = repeater_active_out && rx_valid_in && (hit_hi || hit_lo)
                      && (cfg_r.addr_high_byte != cfg_r.addr_low_byte);

    // Relay onto the opposite network of the pair
    always_comb begin
        fwd_pkt        = rx_pkt_in;
        fwd_pkt.net_id = hit_hi ? cfg_r.addr_low_byte : cfg_r.addr_high_byte;
    end

    // Host data goes out on own network, transparently addressed
    always_comb begin
        host_pkt          = '0;
        host_pkt.net_id   = cfg_r.network_identifier;
        host_pkt.dst_addr = own_addr;
        host_pkt.src_addr = own_addr;
        host_pkt.data     = host_tx_data_in;
    end

    assign host_take  = host_tx_valid_in && host_tx_ready_out;
    // End node delivery only on own network and matching sender address
    assign deliver    = rx_valid_in && !rep_on && (st_r == ST_RUN)
                        && (mode_r == MODE_NORMAL || mode_r == MODE_WOR)
                        && rx_pkt_in.net_id == cfg_r.network_identifier
                        && rx_pkt_in.src_addr == own_addr;
    assign ready_nxt  = !rep_on && (st_nxt == ST_RUN)
                        && (mode_nxt == MODE_NORMAL || mode_nxt == MODE_WOR);
    assign lowp_nxt   = !rep_on && (mode_nxt == MODE_WOR || mode_nxt == MODE_SLEEP);
    assign active_nxt = rep_on && (st_nxt == ST_RUN) && (mode_nxt == MODE_NORMAL);

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            air_tx_valid_out    <= 1'b0;
            air_tx_pkt_out      <= '0;
            host_rx_valid_out   <= 1'b0;
            host_rx_data_out    <= 8'h00;
            host_tx_ready_out   <= 1'b0;
            low_power_out       <= 1'b0;
            repeater_active_out <= 1'b0;
            aux_out             <= 1'b0;
            mode_out            <= MODE_NORMAL;
        end else if (clk_en_in) begin
            air_tx_valid_out    <= fwd_go || host_take;
            air_tx_pkt_out      <= fwd_go ? fwd_pkt : host_pkt;
            host_rx_valid_out   <= deliver;
            host_rx_data_out    <= rx_pkt_in.data;
            host_tx_ready_out   <= ready_nxt;
            low_power_out       <= lowp_nxt;
            repeater_active_out <= active_nxt;
            aux_out             <= (st_nxt == ST_RUN);
            mode_out            <= mode_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [11:0] low_cnt_r;

    // Length of the current low stretch of the status pin
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            low_cnt_r <= 12'h000;
        end else if (clk_en_in) begin
            low_cnt_r <= aux_out ? 12'h000 : low_cnt_r + 12'h001;
        end
    end

    property p_aux_reload;
        @(posedge core_clk_in) disable iff (rst_in)
        (st_r != ST_RUN) |-> !aux_out;
    endproperty
    a_aux_reload: assert property (p_aux_reload) else $error("status high in reload");

    property p_reload_len;
        @(posedge core_clk_in) disable iff (rst_in)
        $rose(aux_out) |-> (low_cnt_r == 12'(RELOAD_LEN) || low_cnt_r == 12'(RELOAD_LEN + 1));
    endproperty
    a_reload_len: assert property (p_reload_len) else $error("reload length wrong");

    property p_hi_to_lo;
        @(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && fwd_go && hit_hi)
            |=> air_tx_valid_out && air_tx_pkt_out.net_id == $past(cfg_r.addr_low_byte);
    endproperty
    a_hi_to_lo: assert property (p_hi_to_lo) else $error("high to low relay wrong");

    property p_lo_to_hi;
        @(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && repeater_active_out && rx_valid_in && hit_lo && !hit_hi)
            |=> air_tx_valid_out && air_tx_pkt_out.net_id == $past(cfg_r.addr_high_byte)
                && air_tx_pkt_out.data == $past(rx_pkt_in.data);
    endproperty
    a_lo_to_hi: assert property (p_lo_to_hi) else $error("low to high relay wrong");

    property p_rep_blocks_host;
        @(posedge core_clk_in) disable iff (rst_in)
        repeater_active_out |-> !host_tx_ready_out && !host_rx_valid_out && !low_power_out;
    endproperty
    a_rep_blocks_host: assert property (p_rep_blocks_host) else $error("host path open");

    property p_rep_needs_normal;
        @(posedge core_clk_in) disable iff (rst_in)
        repeater_active_out |-> mode_out == MODE_NORMAL && aux_out;
    endproperty
    a_rep_needs_normal: assert property (p_rep_needs_normal) else $error("repeat off normal");

    property p_deliver_match;
        @(posedge core_clk_in) disable iff (rst_in)
        (host_rx_valid_out && $past(clk_en_in))
            |-> $past(rx_pkt_in.src_addr) == $past(own_addr)
                              && host_rx_data_out == $past(rx_pkt_in.data);
    endproperty
    a_deliver_match: assert property (p_deliver_match) else $error("delivery mismatch");

    property p_cfg_gate;
        @(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && cfg_wr_in && mode_r != MODE_CONFIG) |-> !wr_ok;
    endproperty
    a_cfg_gate: assert property (p_cfg_gate) else $error("write outside config");

    property p_network_identifier_ignored;
        @(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && fwd_go && rx_pkt_in.net_id != cfg_r.network_identifier)
            |=> air_tx_valid_out;
    endproperty
    a_network_identifier_ignored: assert property (p_network_identifier_ignored) else $error("network_identifier blocked relay");

endmodule : rrf_repeater_ctrl

// ==== rrf_host_model.sv ====
/* Host controller model: drives the mode pins, the parameter port and host data.
   Assumes one clock shared with the design; the testbench calls its tasks. */
`timescale 1ns/1ps
module rrf_host_model
    import rrf_pkg::*;
(
    // Clock and answers
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       ready_in,
    // Pins and strobes
    output logic      [1:0] mode_out,
    output logic            wr_out,
    output logic      [2:0] idx_out,
    output logic      [7:0] wdata_out,
    output logic            tx_valid_out,
    output logic      [7:0] tx_data_out
);
    // Idle levels at time zero
    initial begin
        mode_out     = MODE_NORMAL;
        wr_out       = 1'b0;
        idx_out      = 3'h0;
        wdata_out    = 8'hFF;
        tx_valid_out = 1'b0;
        tx_data_out  = 8'hFF;
    end
    // Move the pins, then give the synchroniser time to settle
    task automatic set_mode(input logic [1:0] m);
        @(posedge clk_in);
        mode_out <= m;
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
    endtask : set_mode
    // One write strobe; the data line shows the inverse once released
    task automatic write(input logic [2:0] i, input logic [7:0] d);
        @(posedge clk_in);
        wr_out    <= 1'b1;
        idx_out   <= i;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        wdata_out <= ~d;
    endtask : write
    // Registered read: the word appears one edge after the index
    task automatic read(input logic [2:0] i, output logic [7:0] d);
        @(posedge clk_in);
        idx_out <= i;
        repeat (2) @(posedge clk_in);
        #1 d = rdata_in;
    endtask : read
    // Offer a host byte for up to four cycles, held until taken
    task automatic send(input logic [7:0] d, output logic taken);
        taken = 1'b0;
        @(posedge clk_in);
        tx_valid_out <= 1'b1;
        tx_data_out  <= d;
        repeat (4) begin
            @(negedge clk_in);
            if (ready_in === 1'b1) begin
                taken = 1'b1;
                break;
            end
        end
        @(posedge clk_in);
        tx_valid_out <= 1'b0;
        tx_data_out  <= ~d;
    endtask : send
endmodule : rrf_host_model

// ==== tb.sv ====
/* Self-checking testbench for the repeater control: host model on the mode and
   parameter side, heard packets driven here. Assumes a short reload of 8 cycles. */
`timescale 1ns/1ps
module tb;
    import rrf_pkg::*;
    localparam int         RL = 8;
    localparam logic [7:0] DEFAULTS [8] = '{8'hC0, 8'h00, 8'h00, 8'h62, 8'h00, 8'h12,
                                            8'h00, 8'h00};
    logic       core_clk_in, rst_in, factory_reset_in, rx_valid_in, taken, clk_en_in;
    logic       host_tx_ready_out, air_tx_valid_out, host_rx_valid_out;
    logic       aux_out, low_power_out, repeater_active_out, cfg_wr_in, host_tx_valid_in;
    logic [1:0] mode_select_pins_in, mode_out;
    logic [2:0] cfg_idx_in;
    logic [7:0] cfg_wdata_in, cfg_rdata_out, host_tx_data_in, host_rx_data_out, rd;
    rrf_pkt_s   rx_pkt_in, air_tx_pkt_out, got;
    int         err_count, check_count, n_tx, n_rx, lows;

    rrf_repeater_ctrl #(.RELOAD_LEN(RL)) rrf_repeater_ctrl_i (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
        .mode_select_pins_in(mode_select_pins_in), .factory_reset_in(factory_reset_in),
        .cfg_wr_in(cfg_wr_in), .cfg_idx_in(cfg_idx_in), .cfg_wdata_in(cfg_wdata_in),
        .cfg_rdata_out(cfg_rdata_out), .rx_valid_in(rx_valid_in), .rx_pkt_in(rx_pkt_in),
        .host_tx_valid_in(host_tx_valid_in), .host_tx_data_in(host_tx_data_in),
        .host_tx_ready_out(host_tx_ready_out), .air_tx_valid_out(air_tx_valid_out),
        .air_tx_pkt_out(air_tx_pkt_out), .host_rx_valid_out(host_rx_valid_out),
        .host_rx_data_out(host_rx_data_out), .aux_out(aux_out),
        .low_power_out(low_power_out), .repeater_active_out(repeater_active_out),
        .mode_out(mode_out));
    rrf_host_model rrf_host_model_i (
        .clk_in(core_clk_in), .rdata_in(cfg_rdata_out), .ready_in(host_tx_ready_out),
        .mode_out(mode_select_pins_in), .wr_out(cfg_wr_in), .idx_out(cfg_idx_in),
        .wdata_out(cfg_wdata_in), .tx_valid_out(host_tx_valid_in),
        .tx_data_out(host_tx_data_in));

    // Clock at 125 MHz
    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    // Compare one result and count it
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        check_count++;
        if (g !== e)
            err_count++;
        if (g !== e)
            $display("Error at %0t: got %0h expected %0h", $time, g, e);
    endtask : chk
    // Print the counts and the verdict, then stop
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    // Count low cycles of the status pin until it rises, bounded
    task automatic wait_aux();
        lows = 0;
        while (aux_out !== 1'b1) begin
            @(negedge core_clk_in);
            if (aux_out !== 1'b1)
                lows++;
            if (lows > 200)
                err_count++;
            if (lows > 200)
                conclude();
        end
    endtask : wait_aux
    // One heard packet, then watch four cycles of both outputs
    task automatic hear(input rrf_pkt_s p);
        n_tx = 0;
        n_rx = 0;
        @(posedge core_clk_in);
        rx_valid_in <= 1'b1;
        rx_pkt_in   <= p;
        @(posedge core_clk_in);
        rx_valid_in <= 1'b0;
        rx_pkt_in   <= ~p;
        repeat (4) begin
            @(negedge core_clk_in);
            if (air_tx_valid_out === 1'b1)
                n_tx++;
            if (air_tx_valid_out === 1'b1)
                got = air_tx_pkt_out;
            if (host_rx_valid_out === 1'b1)
                n_rx++;
            if (host_rx_valid_out === 1'b1)
                rd = host_rx_data_out;
        end
    endtask : hear
    // Read the whole store against the factory set
    task automatic check_store();
        for (int i = 0; i < 8; i++) begin
            rrf_host_model_i.read(3'(i), rd);
            chk(48'(rd), 48'(DEFAULTS[i]));
        end
    endtask : check_store

    // Main sequence
    initial begin
        err_count        = 0;
        check_count      = 0;
        rst_in           = 1'b1;
        clk_en_in        = 1'b1;
        factory_reset_in = 1'b0;
        rx_valid_in      = 1'b0;
        rx_pkt_in        = '0;
        repeat (16) @(posedge core_clk_in);
        rst_in <= 1'b0;
        wait_aux();
        chk(48'(lows), 48'(RL));
        check_store();
        $display("test reset done");
        rrf_host_model_i.set_mode(MODE_CONFIG);
        rrf_host_model_i.write(IDX_ADDR_HI, 8'h08);
        rrf_host_model_i.write(IDX_ADDR_LO, 8'h33);
        rrf_host_model_i.write(IDX_NETWORK_IDENTIFIER, 8'h44);
        rrf_host_model_i.write(IDX_CHANNEL, 8'h51);
        rrf_host_model_i.write(IDX_HEADER, 8'h55);
        rrf_host_model_i.write(IDX_OPT3, 8'h20);
        rrf_host_model_i.read(IDX_CHANNEL, rd);
        chk(48'(rd), 48'h12);
        rrf_host_model_i.read(IDX_HEADER, rd);
        chk(48'(rd), 48'hC0);
        rrf_host_model_i.read(IDX_OPT3, rd);
        chk(48'(rd), 48'h20);
        chk(48'(repeater_active_out), 48'h0);
        rrf_host_model_i.set_mode(MODE_NORMAL);
        chk({46'h0, repeater_active_out, low_power_out}, 48'h2);
        $display("test configure done");
        hear({8'h08, 16'h1234, 16'h5678, 8'hA5});
        chk(48'(n_tx), 48'h1);
        chk(got, {8'h33, 16'h1234, 16'h5678, 8'hA5});
        hear({8'h33, 16'h0001, 16'h0002, 8'h3C});
        chk(48'(n_tx), 48'h1);
        chk(got, {8'h08, 16'h0001, 16'h0002, 8'h3C});
        hear({8'h44, 16'h0808, 16'h3333, 8'h11});
        chk(48'({n_tx[7:0], n_rx[7:0]}), 48'h0);
        rrf_host_model_i.send(8'h77, taken);
        chk(48'(taken), 48'h0);
        rrf_host_model_i.set_mode(MODE_WOR);
        chk(48'(low_power_out), 48'h0);
        chk(48'(mode_out), 48'(MODE_WOR));
        $display("test relay done");
        rrf_host_model_i.set_mode(MODE_SLEEP);
        rrf_host_model_i.set_mode(MODE_NORMAL);
        chk(48'(aux_out), 48'h0);
        // Freeze four edges mid-reload: the reload must stretch by the same four
        @(posedge core_clk_in);
        clk_en_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        clk_en_in <= 1'b1;
        wait_aux();
        chk(48'(lows), 48'(RL - 3));
        @(posedge core_clk_in);
        factory_reset_in <= 1'b1;
        @(posedge core_clk_in);
        factory_reset_in <= 1'b0;
        @(negedge core_clk_in);
        wait_aux();
        check_store();
        $display("test reload done");
        hear({8'h00, 16'h0000, 16'h0000, 8'h5A});
        chk({n_rx[15:0], 24'h0, rd}, {16'h1, 24'h0, 8'h5A});
        hear({8'h00, 16'h0000, 16'h0007, 8'h5B});
        chk(48'(n_rx), 48'h0);
        rrf_host_model_i.send(8'h66, taken);
        chk(48'(taken), 48'h1);
        // Taken byte goes on air in the edge after the take, own network and address
        @(negedge core_clk_in);
        chk(48'(air_tx_valid_out), 48'h1);
        chk(air_tx_pkt_out, {8'h00, 16'h0000, 16'h0000, 8'h66});
        rrf_host_model_i.set_mode(MODE_SLEEP);
        chk(48'(low_power_out), 48'h1);
        $display("test end node done");
        conclude();
    end
endmodule : tb
